// File: kpi_params.svh
`ifndef KPI_PARAMS_SVH
`define KPI_PARAMS_SVH

`define KPI_NUM_PINS 7
`define KPI_MAX_PINS 8

`define KPI_ADDR_W 12
`define KPI_OFS_STATUS_CTRL 12'h000
`define KPI_OFS_PIN_ENABLE 12'h004
`define KPI_OFS_POLARITY 12'h008

`define KPI_SEL_SC 2'h0
`define KPI_SEL_EN 2'h1
`define KPI_SEL_POL 2'h2
`define KPI_SEL_NONE 2'h3

`define KPI_SC_FLAG 3
`define KPI_SC_ACK 2
`define KPI_SC_IE 1
`define KPI_SC_MODE 0

`define KPI_RST_BYTE 8'h00
`define KPI_HSIZE_WORD 3'h2
`define KPI_HRESP_OKAY 1'b0

`endif

// File: kpi_pkg.sv
`default_nettype none

package kpi_pkg;

    typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ} kpi_phase_t;

    typedef struct packed {
        kpi_phase_t phase;
        logic [1:0] reg_sel;
        logic ie;
        logic mode;
        logic flag;
        logic armed;
        logic [7:0] pin_en;
        logic [7:0] pol;
        logic [7:0] rdata;
        logic irq;
        logic [7:0] pull;
        logic hready;
    } kpi_top_st_t;

    typedef struct packed {
        logic [7:0] prev;
    } kpi_det_st_t;

    typedef struct packed {
        logic wake;
    } kpi_wake_st_t;

endpackage

`default_nettype wire

// File: kpi_pin_detect.sv
`timescale 1ns/10ps
`default_nettype none
`include "kpi_params.svh"

module kpi_pin_detect #(
    parameter int NUM_PINS = `KPI_NUM_PINS
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_clear,
    input wire logic [7:0] i_pins,
    input wire logic [7:0] i_pin_en,
    input wire logic [7:0] i_pol,
    output logic [7:0] o_level,
    output logic [7:0] o_edge
);
    import kpi_pkg::*;

    kpi_det_st_t st_ff;
    kpi_det_st_t nxt_st;
    logic [7:0] asserted;

    genvar g;
    generate
        for (g = 0; g < `KPI_MAX_PINS; g++)
        begin : g_pin
            if (g < NUM_PINS)
            begin : g_live
                // pol 0 asserts low, pol 1 asserts high
                assign asserted[g] = i_pin_en[g] & ~(i_pins[g] ^ i_pol[g]);
            end
            else
            begin : g_absent
                assign asserted[g] = 1'b0;
            end
            // deasserted one cycle, asserted the next
            assign o_edge[g] = asserted[g] & ~st_ff.prev[g];
        end
    endgenerate

    assign o_level = asserted;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.prev = i_clear ? `KPI_RST_BYTE : asserted;
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    disabled_pin_quiet_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (o_level & ~i_pin_en) == 8'h00)
        else $error("disabled pin reported as asserted");

endmodule
`default_nettype wire

// File: kpi_wake.sv
`timescale 1ns/10ps
`default_nettype none

module kpi_wake (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_flag,
    input wire logic i_irq_enable,
    input wire logic i_wait_mode,
    input wire logic i_shallow_stop,
    input wire logic i_deep_stop,
    output logic o_wake
);
    import kpi_pkg::*;

    kpi_wake_st_t st_ff;
    kpi_wake_st_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        // deep stop disables the unit, so no wake from it here
        nxt_st.wake = i_flag & i_irq_enable & ~i_deep_stop
            & (i_wait_mode | i_shallow_stop);
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign o_wake = st_ff.wake;

    low_power_wake_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_flag && i_irq_enable && !i_deep_stop
            && (i_wait_mode || i_shallow_stop)) |=> o_wake)
        else $error("wake not raised in low power mode");

    no_wake_masked_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        !i_irq_enable |=> !o_wake)
        else $error("wake raised while interrupt disabled");

endmodule
`default_nettype wire

// File: kpi_top.sv
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "kpi_params.svh"

// Function
// - seven key pins, each separately enabled
// - falling, falling+low, rising, rising+high triggers
// - all pins share one enabled request
// - three byte registers: control, enables, polarity
// - control bits 7:4 read zero
// - event flag read only, writes ignored
// - acknowledge write clears flag, reads zero
// - interrupt enable gates the request
// - mode bit: edges only or edges+levels
// - keeps detecting in wait, wakes processor
// - detects in shallow stop, wakes processor
// - deep stop disables and resets everything
// - debug mode changes nothing
// - polarity picks pullup or pulldown
// - pin enable bit admits the pin
// - polarity bit picks low or high
// - edge needs rearm by all deasserted
// - level mode ack keeps flag while asserted
module kpi_top #(
    parameter int NUM_PINS = `KPI_NUM_PINS
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic O_HREADYOUT,
    output logic [31:0] O_HRDATA,
    output logic O_HRESP,
    input wire logic [7:0] I_KEY_INPUT_PIN,
    input wire logic I_WAIT_MODE,
    input wire logic I_SHALLOW_STOP_MODE,
    input wire logic I_DEEP_STOP_MODE,
    output logic O_KEY_IRQ,
    output logic O_WAKEUP,
    output logic [7:0] O_PULL_DOWN_SEL
);
    import kpi_pkg::*;

    localparam logic [7:0] PIN_MASK =
        8'((32'h1 << NUM_PINS) - 32'h1);

    localparam kpi_top_st_t TOP_RST = '{
        phase: PH_IDLE,
        reg_sel: `KPI_SEL_NONE,
        ie: 1'b0,
        mode: 1'b0,
        flag: 1'b0,
        armed: 1'b0,
        pin_en: `KPI_RST_BYTE,
        pol: `KPI_RST_BYTE,
        rdata: `KPI_RST_BYTE,
        irq: 1'b0,
        pull: `KPI_RST_BYTE,
        hready: 1'b1
    };

    kpi_top_st_t st_ff;
    kpi_top_st_t nxt_st;

    logic [7:0] pin_level;
    logic [7:0] pin_edge;
    logic any_level;
    logic any_edge;
    logic access;
    logic [1:0] addr_sel;
    logic [7:0] rd_val;
    logic [7:0] wdata;
    logic wr_sc;
    logic ack;
    logic set_ev;
    logic clr_ev;

    kpi_pin_detect #(
        .NUM_PINS(NUM_PINS)
    ) u_detect (
        .i_clk(I_CORE_CLK),
        .i_reset(I_RESET),
        .i_clear(I_DEEP_STOP_MODE),
        .i_pins(I_KEY_INPUT_PIN),
        .i_pin_en(st_ff.pin_en),
        .i_pol(st_ff.pol),
        .o_level(pin_level),
        .o_edge(pin_edge)
    );

    kpi_wake u_wake (
        .i_clk(I_CORE_CLK),
        .i_reset(I_RESET),
        .i_flag(st_ff.flag),
        .i_irq_enable(st_ff.ie),
        .i_wait_mode(I_WAIT_MODE),
        .i_shallow_stop(I_SHALLOW_STOP_MODE),
        .i_deep_stop(I_DEEP_STOP_MODE),
        .o_wake(O_WAKEUP)
    );

    // all pins fold into one event source
    assign any_level = |pin_level;
    assign any_edge = |pin_edge;

    // byte or halfword accesses are ignored; a read returns the data latched at the last word access, read or write
    assign access = I_HSEL & I_HTRANS[1] & I_HREADY
        & (I_HSIZE == `KPI_HSIZE_WORD);
    assign wdata = I_HWDATA[7:0];

    always_comb
    begin
        case (I_HADDR[`KPI_ADDR_W-1:0])
            `KPI_OFS_STATUS_CTRL: addr_sel = `KPI_SEL_SC;
            `KPI_OFS_PIN_ENABLE: addr_sel = `KPI_SEL_EN;
            `KPI_OFS_POLARITY: addr_sel = `KPI_SEL_POL;
            default: addr_sel = `KPI_SEL_NONE;
        endcase
    end

    always_comb
    begin
        case (addr_sel)
            `KPI_SEL_SC: rd_val = {4'h0, st_ff.flag, 1'b0,
                st_ff.ie, st_ff.mode};
            `KPI_SEL_EN: rd_val = st_ff.pin_en;
            `KPI_SEL_POL: rd_val = st_ff.pol;
            default: rd_val = 8'h00;
        endcase
    end

    assign wr_sc = (st_ff.phase == PH_WRITE)
        && (st_ff.reg_sel == `KPI_SEL_SC);
    assign ack = wr_sc & wdata[`KPI_SC_ACK];

    // first edge needs an armed unit; level mode sets on any level
    assign set_ev = (st_ff.armed & any_edge)
        | (st_ff.mode & any_level);
    // a pin still asserted in level mode blocks the clear
    assign clr_ev = ack & ~(st_ff.mode & any_level);

    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff.phase)
            PH_IDLE:
            begin
                nxt_st.phase = PH_IDLE;
            end
            PH_WRITE:
            begin
                case (st_ff.reg_sel)
                    `KPI_SEL_SC:
                    begin
                        // flag bit of the write data is dropped
                        nxt_st.ie = wdata[`KPI_SC_IE];
                        nxt_st.mode = wdata[`KPI_SC_MODE];
                    end
                    `KPI_SEL_EN: nxt_st.pin_en = wdata & PIN_MASK;
                    `KPI_SEL_POL: nxt_st.pol = wdata & PIN_MASK;
                    default: nxt_st.pin_en = st_ff.pin_en;
                endcase
            end
            PH_READ:
            begin
                nxt_st.phase = PH_IDLE;
            end
            default:
            begin
                nxt_st.phase = PH_IDLE;
            end
        endcase

        if (access)
        begin
            nxt_st.phase = I_HWRITE ? PH_WRITE : PH_READ;
            nxt_st.reg_sel = addr_sel;
            nxt_st.rdata = rd_val;
        end
        else
        begin
            nxt_st.phase = PH_IDLE;
        end

        // set wins over an acknowledge in the same cycle
        nxt_st.flag = set_ev | (st_ff.flag & ~clr_ev);
        if (!any_level)
            nxt_st.armed = 1'b1;
        else if (st_ff.armed && any_edge)
            nxt_st.armed = 1'b0;

        nxt_st.irq = nxt_st.flag & nxt_st.ie;
        nxt_st.pull = nxt_st.pin_en & nxt_st.pol;
        nxt_st.hready = 1'b1;

        // deep stop leaves the unit as if just reset
        if (I_DEEP_STOP_MODE)
            nxt_st = TOP_RST;
    end

    // no debug input: detection runs the same in background mode
    always_ff @(posedge I_CORE_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            st_ff <= TOP_RST;
        else
            st_ff <= nxt_st;
    end

    assign O_HREADYOUT = st_ff.hready;
    assign O_HRDATA = {24'h000000, st_ff.rdata};
    assign O_HRESP = `KPI_HRESP_OKAY;
    assign O_KEY_IRQ = st_ff.irq;
    assign O_PULL_DOWN_SEL = st_ff.pull;

    irq_is_flag_ie_a: assert property (
        @(posedge I_CORE_CLK) disable iff (I_RESET)
        O_KEY_IRQ == (st_ff.flag && st_ff.ie))
        else $error("request differs from flag and enable");

    sc_read_zeros_a: assert property (
        @(posedge I_CORE_CLK) disable iff (I_RESET)
        (access && !I_HWRITE && addr_sel == `KPI_SEL_SC)
        |=> (O_HRDATA[31:4] == 28'h0) && !O_HRDATA[`KPI_SC_ACK])
        else $error("unused or ack bits read nonzero");

    sc_read_flag_a: assert property (
        @(posedge I_CORE_CLK) disable iff (I_RESET)
        (access && !I_HWRITE && addr_sel == `KPI_SEL_SC
            && !I_DEEP_STOP_MODE)
        |=> O_HRDATA[`KPI_SC_FLAG] == $past(st_ff.flag))
        else $error("flag read back wrong");

    edge_sets_flag_a: assert property (
        @(posedge I_CORE_CLK) disable iff (I_RESET)
        (st_ff.armed && any_edge && !I_DEEP_STOP_MODE) |=> st_ff.flag)
        else $error("armed edge did not set flag");

    edge_disarms_a: assert property (
        @(posedge I_CORE_CLK) disable iff (I_RESET)
        (st_ff.armed && any_edge && !I_DEEP_STOP_MODE)
        |=> !st_ff.armed)
        else $error("unit stayed armed after an edge");

    level_keeps_flag_a: assert property (
        @(posedge I_CORE_CLK) disable iff (I_RESET)
        (st_ff.mode && any_level && !I_DEEP_STOP_MODE) |=> st_ff.flag)
        else $error("asserted level did not hold flag");

    ack_clears_a: assert property (
        @(posedge I_CORE_CLK) disable iff (I_RESET)
        (st_ff.flag && ack && !set_ev) |=> !st_ff.flag)
        else $error("acknowledge did not clear flag");

    flag_write_none_a: assert property (
        @(posedge I_CORE_CLK) disable iff (I_RESET)
        (!st_ff.flag && wr_sc && !set_ev) |=> !st_ff.flag)
        else $error("write set the flag");

    edge_mode_no_level_a: assert property (
        @(posedge I_CORE_CLK) disable iff (I_RESET)
        (!st_ff.flag && !st_ff.mode && !any_edge) |=> !st_ff.flag)
        else $error("flag set without edge in edge mode");

    deep_stop_reset_a: assert property (
        @(posedge I_CORE_CLK) disable iff (I_RESET)
        I_DEEP_STOP_MODE |=> (st_ff.pin_en == 8'h00)
        && (st_ff.pol == 8'h00) && !st_ff.flag && !st_ff.ie
        && !st_ff.mode && !O_KEY_IRQ)
        else $error("deep stop left state set");

    pull_select_a: assert property (
        @(posedge I_CORE_CLK) disable iff (I_RESET)
        O_PULL_DOWN_SEL == (st_ff.pin_en & st_ff.pol))
        else $error("pull direction mismatched");

    absent_pin_off_a: assert property (
        @(posedge I_CORE_CLK) disable iff (I_RESET)
        (st_ff.pin_en & ~PIN_MASK) == 8'h00)
        else $error("absent pin enabled");

    write_enable_a: assert property (
        @(posedge I_CORE_CLK) disable iff (I_RESET)
        (st_ff.phase == PH_WRITE && st_ff.reg_sel == `KPI_SEL_EN
            && !I_DEEP_STOP_MODE)
        |=> st_ff.pin_en == ($past(I_HWDATA[7:0]) & PIN_MASK))
        else $error("pin enable write lost");

    flag_holds_a: assert property (
        @(posedge I_CORE_CLK) disable iff (I_RESET)
        (st_ff.flag && !ack && !I_DEEP_STOP_MODE) |=> st_ff.flag)
        else $error("flag dropped without acknowledge");

    rearm_idle_a: assert property (
        @(posedge I_CORE_CLK) disable iff (I_RESET)
        (!any_level && !I_DEEP_STOP_MODE) |=> st_ff.armed)
        else $error("unit not rearmed with all pins idle");

endmodule
`default_nettype wire

// File: kpi_key_src.sv
`timescale 1ns/10ps
`default_nettype none

module kpi_key_src (
    input wire logic i_clk,
    input wire logic [6:0] i_level,
    output logic [7:0] o_pins
);
    // absent pin 7 rests on its pull-up, never asserted for falling mode
    always @(posedge i_clk)
    begin
        o_pins <= {1'b1, i_level};
    end
endmodule

`default_nettype wire

// File: kpi_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "kpi_params.svh"

module kpi_tb_top;
    import kpi_pkg::*;
    localparam logic [11:0] SC = `KPI_OFS_STATUS_CTRL;
    localparam logic [11:0] EN = `KPI_OFS_PIN_ENABLE;
    localparam logic [11:0] PL = `KPI_OFS_POLARITY;
    logic clk, rst, hsel, hwrite, hready, hresp, irq, wake;
    logic wmode, smode, dmode;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] pins, pulldn, rd;
    logic [6:0] lvl;
    int bad_count, checks;

    kpi_key_src keys_src (.i_clk(clk), .i_level(lvl), .o_pins(pins));
    kpi_top dut (
        .I_CORE_CLK(clk), .I_RESET(rst), .I_HSEL(hsel),
        .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
        .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
        .O_HREADYOUT(hready), .O_HRDATA(hrdata), .O_HRESP(hresp),
        .I_KEY_INPUT_PIN(pins), .I_WAIT_MODE(wmode),
        .I_SHALLOW_STOP_MODE(smode), .I_DEEP_STOP_MODE(dmode),
        .O_KEY_IRQ(irq), .O_WAKEUP(wake), .O_PULL_DOWN_SEL(pulldn)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d bad %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // compares at the falling edge so registered outputs have landed
    task automatic chk8(ref logic [7:0] g, input logic [7:0] e);
        @(negedge clk);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
        @(posedge clk);
    endtask

    task automatic chk1(ref logic g, input logic e);
        @(negedge clk);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %0t got %b want %b", $time, g, e);
        end
        @(posedge clk);
    endtask

    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        @(posedge clk);
        while (hready !== 1'b1)
            @(posedge clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h0, d};
        @(posedge clk);
        while (hready !== 1'b1)
            @(posedge clk);
        rd = hrdata[7:0];
        // idle cycle: a read overlapping a write's data phase sees old data
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk8(rd, e);
    endtask

    task automatic keys(input logic [6:0] v);
        lvl <= v;
        repeat (4) @(posedge clk);
    endtask

    initial
    begin
        repeat (5000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end

    initial
    begin
        bad_count = 0;
        checks = 0;
        rst = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = `KPI_HSIZE_WORD;
        wmode = 1'b0;
        smode = 1'b0;
        dmode = 1'b0;
        lvl = 7'h7F;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdchk(SC, 8'h00);
        rdchk(EN, 8'h00);
        rdchk(PL, 8'h00);
        chk1(hresp, 1'b0);
        wr(12'h00C, 8'hFF);
        rdchk(12'h00C, 8'h00);
        hsize <= 3'h0;
        wr(EN, 8'hFF);
        hsize <= `KPI_HSIZE_WORD;
        rdchk(EN, 8'h00);
        wr(SC, 8'hFF);
        rdchk(SC, 8'h03);
        chk1(irq, 1'b0);
        wr(SC, 8'h00);
        wr(EN, 8'hFF);
        wr(PL, 8'hFF);
        rdchk(EN, 8'h7F);
        rdchk(PL, 8'h7F);
        chk8(pulldn, 8'h7F);
        wr(EN, 8'h00);
        wr(PL, 8'h00);
        $display("test registers done");
        // the polarity write above raised a stray flag; clear it first
        wr(SC, 8'h06);
        rdchk(SC, 8'h02);
        wr(EN, 8'h03);
        keys(7'h7E);
        rdchk(SC, 8'h0A);
        chk1(irq, 1'b1);
        wr(SC, 8'h06);
        rdchk(SC, 8'h02);
        chk1(irq, 1'b0);
        keys(7'h7C);
        rdchk(SC, 8'h02);
        keys(7'h7F);
        keys(7'h7B);
        rdchk(SC, 8'h02);
        keys(7'h7D);
        rdchk(SC, 8'h0A);
        $display("test falling edge done");
        wr(EN, 8'h00);
        wr(PL, 8'h02);
        wr(EN, 8'h02);
        wr(SC, 8'h06);
        rdchk(SC, 8'h02);
        chk8(pulldn, 8'h02);
        keys(7'h7F);
        rdchk(SC, 8'h0A);
        $display("test rising edge done");
        wr(SC, 8'h07);
        rdchk(SC, 8'h0B);
        wr(SC, 8'h07);
        rdchk(SC, 8'h0B);
        keys(7'h7D);
        rdchk(SC, 8'h0B);
        wr(SC, 8'h07);
        rdchk(SC, 8'h03);
        $display("test level done");
        wr(SC, 8'h05);
        keys(7'h7F);
        rdchk(SC, 8'h09);
        chk1(irq, 1'b0);
        wmode <= 1'b1;
        chk1(wake, 1'b0);
        wr(SC, 8'h03);
        chk1(irq, 1'b1);
        chk1(wake, 1'b1);
        wmode <= 1'b0;
        smode <= 1'b1;
        @(posedge clk);
        chk1(wake, 1'b1);
        dmode <= 1'b1;
        @(posedge clk);
        dmode <= 1'b0;
        rdchk(SC, 8'h00);
        rdchk(EN, 8'h00);
        rdchk(PL, 8'h00);
        chk1(irq, 1'b0);
        chk1(wake, 1'b0);
        smode <= 1'b0;
        $display("test low power done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
